// ---- hdl/uart_shadow_defines.vh ----
// Address map, field positions, reset values and sizes of the UART shadow data port
`ifndef UART_SHADOW_DEFINES_VH
`define UART_SHADOW_DEFINES_VH

// Sixteen aliased shadow data words, first and last byte address
`define SHADOW_BASE 32'h50001030
`define SHADOW_LAST 32'h5000106C
// The alias word this block is documented under (index 3 of 16)
`define SHADOW_THIS 32'h5000103C
`define SHADOW_ALIASES 16

// Control and status words of this block
`define CTRL_ADDR 32'h50001100
`define STAT_ADDR 32'h50001104

// Control fields
`define CTRL_FIFO_EN_BIT 0
`define CTRL_IR_MODE_BIT 1
`define CTRL_WIDTH 2
`define CTRL_RESET 2'h0

// Status fields
`define STAT_READY_BIT 0
`define STAT_OVERRUN_BIT 1
`define STAT_TXEMPTY_BIT 5
`define STAT_RXFULL_BIT 6
`define STAT_TXFULL_BIT 7
`define STAT_RXLEVEL_LSB 8
`define STAT_TXLEVEL_LSB 16

// Data byte and FIFO sizes
`define DATA_WIDTH 8
`define DATA_RESET 8'h00
`define FIFO_DEPTH 16
`define FIFO_AW 4

// AHB transfer type bit that marks NONSEQ or SEQ
`define HTRANS_ACTIVE_BIT 1

`endif

// ---- hdl/uart_byte_fifo.v ----
// Synchronous byte FIFO with flush and fill level, used for receive and transmit
`timescale 1ns/1ps
module uart_byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  input wire flush,
  // Fill side
  input wire inValid,
  input wire [WIDTH-1:0] inData,
  output wire inReady,
  // Drain side
  output wire outValid,
  output wire [WIDTH-1:0] outData,
  input wire outReady,
  // Fill level
  output wire [AW:0] level
);
  localparam [AW:0] FULL_COUNT = DEPTH[AW:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  // Full refuses, it never overwrites stored entries
  assign inReady = (count_r != FULL_COUNT);
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_r];
  assign level = count_r;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // Storage array, no reset needed
  always @(posedge mclk)
  begin
    if (push)
      mem[wrPtr_r] <= inData;
  end

  // Pointers wrap naturally, depth is a power of two
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rdPtr_r <= rdPtr_r + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // uart_byte_fifo

// ---- hdl/uart_tx_skid.v ----
// Two-entry buffer between the transmit store and the serial shifter
`timescale 1ns/1ps
module uart_tx_skid #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Fill side
  input wire inValid,
  input wire [WIDTH-1:0] inData,
  output wire inReady,
  // Drain side
  output wire outValid,
  output wire [WIDTH-1:0] outData,
  input wire outReady
);
  reg [WIDTH-1:0] head_r;
  reg [WIDTH-1:0] spare_r;
  reg headValid_r;
  reg spareValid_r;
  wire pushIn;
  wire popOut;

  // Ready comes from a flop, so no path from the shifter back to the source
  assign inReady = ~spareValid_r;
  assign outValid = headValid_r;
  assign outData = head_r;
  assign pushIn = inValid & ~spareValid_r;
  assign popOut = headValid_r & outReady;

  // Head drains first, spare catches a word taken during a stall
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      head_r <= {WIDTH{1'b0}};
      spare_r <= {WIDTH{1'b0}};
      headValid_r <= 1'b0;
      spareValid_r <= 1'b0;
    end
    else if (popOut)
    begin
      if (spareValid_r)
      begin
        head_r <= spare_r;
        spareValid_r <= 1'b0;
      end
      else if (pushIn)
        head_r <= inData;
      else
        headValid_r <= 1'b0;
    end
    else if (pushIn)
    begin
      if (!headValid_r)
      begin
        head_r <= inData;
        headValid_r <= 1'b1;
      end
      else
      begin
        spare_r <= inData;
        spareValid_r <= 1'b1;
      end
    end
  end
endmodule // uart_tx_skid

// ---- hdl/uart_shadow_data_port.v ----
// UART shadow receive/transmit data location behind an AHB-Lite slave
`timescale 1ns/1ps
`include "uart_shadow_defines.vh"
module uart_shadow_data_port (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Received bytes from the UART and infrared deserialisers
  input wire rxUartValid,
  input wire [7:0] rxUartByte,
  input wire rxIrValid,
  input wire [7:0] rxIrByte,
  // Bytes to the serial shifter
  output wire txValid,
  output wire [7:0] txByte,
  input wire txReady,
  output wire txIrSel,
  // Line status signals
  output wire rxByteReadyFlag,
  output wire txHoldingEmptyFlag,
  output wire overrunFlag,
  output wire fifoEnable
);
  // Address phase decode
  wire addrPhase;
  wire wordAligned;
  wire hitShadow;
  wire hitCtrl;
  wire hitStat;
  wire rdShadow;
  wire rdCtrl;
  wire rdStat;
  wire wrShadowHit;
  wire wrCtrlHit;

  // Data phase write strobes
  reg wrShadow_r;
  reg wrCtrl_r;

  // Control register
  reg [`CTRL_WIDTH-1:0] ctrl_r;
  wire [`CTRL_WIDTH-1:0] ctrl_nxt;
  wire fifoEn;
  wire irMode;
  wire flush;

  // Receive path
  wire rxInValid;
  wire [7:0] rxInByte;
  wire rxPop;
  wire rxFifoInReady;
  wire rxFifoValid;
  wire [7:0] rxFifoByte;
  wire [`FIFO_AW:0] rxLevel;
  reg [7:0] rxHold_r;
  reg rxHoldValid_r;
  wire [7:0] headByte;
  reg overrun_r;
  wire overrunSet;
  wire overwriteLoss;
  wire fullLoss;

  // Transmit path
  wire [7:0] wrByte;
  wire txFifoInReady;
  wire txFifoValid;
  wire [7:0] txFifoByte;
  wire [`FIFO_AW:0] txLevel;
  reg [7:0] txHold_r;
  reg txHoldValid_r;
  wire srcValid;
  wire [7:0] srcByte;
  wire bufReady;
  wire txFifoEmpty;
  wire txHoldEmpty;

  // Read data for the next data phase
  reg [31:0] readWord;
  reg [31:0] statWord;
  wire [2:0] readSel;
  wire rxFull;
  wire txFull;

  // One-hot read region codes, the address ranges never overlap
  localparam [2:0] SEL_SHADOW = 3'h4;
  localparam [2:0] SEL_CTRL = 3'h2;
  localparam [2:0] SEL_STAT = 3'h1;

  // Transfer size is not decoded, every access is taken as a whole word
  // Zero wait states and only OKAY answers
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // A transfer is taken when selected, active and the bus is ready
  assign addrPhase = hsel & hready & htrans[`HTRANS_ACTIVE_BIT];
  assign wordAligned = (haddr[1:0] == 2'h0);
  // Any of the sixteen alias words hits the same data
  assign hitShadow = wordAligned && (haddr >= `SHADOW_BASE) && (haddr <= `SHADOW_LAST);
  assign hitCtrl = (haddr == `CTRL_ADDR);
  assign hitStat = (haddr == `STAT_ADDR);
  assign rdShadow = addrPhase & ~hwrite & hitShadow;
  assign rdCtrl = addrPhase & ~hwrite & hitCtrl;
  assign rdStat = addrPhase & ~hwrite & hitStat;
  assign wrShadowHit = addrPhase & hwrite & hitShadow;
  assign wrCtrlHit = addrPhase & hwrite & hitCtrl;

  // Write data only arrives in the data phase, so the decode is held a cycle
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wrShadow_r <= 1'b0;
      wrCtrl_r <= 1'b0;
    end
    else
    begin
      wrShadow_r <= wrShadowHit;
      wrCtrl_r <= wrCtrlHit;
    end
  end

  // Control word, forwarded so a read right after a write sees the new value
  assign ctrl_nxt = wrCtrl_r ? hwdata[`CTRL_WIDTH-1:0] : ctrl_r;

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      ctrl_r <= `CTRL_RESET;
    else
      ctrl_r <= ctrl_nxt;
  end

  assign fifoEn = ctrl_r[`CTRL_FIFO_EN_BIT];
  assign irMode = ctrl_r[`CTRL_IR_MODE_BIT];
  // Switching FIFO mode empties both stores, mixing the two would reorder bytes
  assign flush = wrCtrl_r & (hwdata[`CTRL_FIFO_EN_BIT] != fifoEn);
  assign fifoEnable = fifoEn;
  assign txIrSel = irMode;

  // Receive source follows the mode
  assign rxInValid = irMode ? rxIrValid : rxUartValid;
  assign rxInByte = irMode ? rxIrByte : rxUartByte;

  // A read only pops when there is something to pop
  assign rxPop = rdShadow & rxByteReadyFlag;

  // Receive FIFO, refuses new bytes while full
  uart_byte_fifo #(
    .WIDTH(`DATA_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) rxFifo (
    .mclk(mclk),
    .rst(rst),
    .flush(flush),
    .inValid(fifoEn & rxInValid),
    .inData(rxInByte),
    .inReady(rxFifoInReady),
    .outValid(rxFifoValid),
    .outData(rxFifoByte),
    .outReady(fifoEn & rxPop),
    .level(rxLevel)
  );

  // Single receive buffer used with FIFOs off
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rxHold_r <= `DATA_RESET;
      rxHoldValid_r <= 1'b0;
    end
    else if (flush)
      rxHoldValid_r <= 1'b0;
    else if (!fifoEn)
    begin
      if (rxInValid)
      begin
        rxHold_r <= rxInByte;
        rxHoldValid_r <= 1'b1;
      end
      else if (rxPop)
        rxHoldValid_r <= 1'b0;
    end
  end

  // Byte ready: buffer full or FIFO not empty
  assign rxByteReadyFlag = fifoEn ? rxFifoValid : rxHoldValid_r;
  assign headByte = fifoEn ? rxFifoByte : rxHold_r;

  // Overrun on overwrite or on a drop at a full FIFO
  assign overwriteLoss = ~fifoEn & rxInValid & rxHoldValid_r & ~rxPop;
  assign fullLoss = fifoEn & rxInValid & ~rxFifoInReady;
  assign overrunSet = overwriteLoss | fullLoss;

  // Sticky, cleared by reading status; a new overrun in that cycle wins
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      overrun_r <= 1'b0;
    else
      overrun_r <= overrunSet | (overrun_r & ~rdStat);
  end

  assign overrunFlag = overrun_r;

  // Only the low byte of a write carries data
  assign wrByte = hwdata[7:0];

  // Transmit FIFO; a write that finds it full is simply lost
  uart_byte_fifo #(
    .WIDTH(`DATA_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) txFifo (
    .mclk(mclk),
    .rst(rst),
    .flush(flush),
    .inValid(fifoEn & wrShadow_r),
    .inData(wrByte),
    .inReady(txFifoInReady),
    .outValid(txFifoValid),
    .outData(txFifoByte),
    .outReady(fifoEn & bufReady),
    .level(txLevel)
  );

  // Single holding byte used with FIFOs off; a new write replaces it
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      txHold_r <= `DATA_RESET;
      txHoldValid_r <= 1'b0;
    end
    else if (flush)
      txHoldValid_r <= 1'b0;
    else if (!fifoEn)
    begin
      if (wrShadow_r)
      begin
        txHold_r <= wrByte;
        txHoldValid_r <= 1'b1;
      end
      else if (bufReady)
        txHoldValid_r <= 1'b0;
    end
  end

  // Empty per store; in FIFO mode the skid entries do not count
  assign txFifoEmpty = ~txFifoValid;
  assign txHoldEmpty = ~txHoldValid_r;

  // Software is expected to write only while this is set
  assign txHoldingEmptyFlag = fifoEn ? txFifoEmpty : txHoldEmpty;

  // Whichever store is active feeds the shifter buffer
  assign srcValid = fifoEn ? txFifoValid : txHoldValid_r;
  assign srcByte = fifoEn ? txFifoByte : txHold_r;

  // Two entries absorb a shifter stall without losing a byte
  uart_tx_skid #(
    .WIDTH(`DATA_WIDTH)
  ) txBuf (
    .mclk(mclk),
    .rst(rst),
    .inValid(srcValid),
    .inData(srcByte),
    .inReady(bufReady),
    .outValid(txValid),
    .outData(txByte),
    .outReady(txReady)
  );

  // Full only has a meaning while the FIFOs are on
  assign rxFull = fifoEn & ~rxFifoInReady;
  assign txFull = fifoEn & ~txFifoInReady;

  // Status word; flags lag a write still in its data phase by one cycle
  always @*
  begin
    statWord = 32'h00000000;
    statWord[`STAT_READY_BIT] = rxByteReadyFlag;
    statWord[`STAT_OVERRUN_BIT] = overrun_r;
    statWord[`STAT_TXEMPTY_BIT] = txHoldingEmptyFlag;
    statWord[`STAT_RXFULL_BIT] = rxFull;
    statWord[`STAT_TXFULL_BIT] = txFull;
    statWord[`STAT_RXLEVEL_LSB+`FIFO_AW:`STAT_RXLEVEL_LSB] = rxLevel;
    statWord[`STAT_TXLEVEL_LSB+`FIFO_AW:`STAT_TXLEVEL_LSB] = txLevel;
  end

  // Regions are exclusive, so the select is one-hot or zero
  assign readSel = {hitShadow, hitCtrl, hitStat};

  // Read mux; unmapped addresses read as zero
  always @*
  begin
    readWord = 32'h00000000;
    case (readSel)
      SEL_SHADOW:
        readWord[7:0] = headByte;
      SEL_CTRL:
        readWord[`CTRL_WIDTH-1:0] = ctrl_nxt;
      SEL_STAT:
        readWord = statWord;
      default:
        readWord = 32'h00000000;
    endcase
  end

  // Read data registered at the address phase, valid through the data phase
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h00000000;
    else if (addrPhase && !hwrite)
      hrdata <= readWord;
  end
endmodule // uart_shadow_data_port

// ---- verification/uart_shadow_monitor.sv ----
// Pin-level checks of the shadow data port
`timescale 1ns/1ps
`include "uart_shadow_defines.vh"
module uart_shadow_monitor (
  // Clock, reset and bus
  input wire mclk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // Data paths and flags
  input wire rxUartValid,
  input wire rxIrValid,
  input wire txValid,
  input wire [7:0] txByte,
  input wire txReady,
  input wire txIrSel,
  input wire rxByteReadyFlag,
  input wire txHoldingEmptyFlag,
  input wire overrunFlag,
  input wire fifoEnable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire hit = hsel && hready && htrans[`HTRANS_ACTIVE_BIT] && haddr >= `SHADOW_BASE && haddr <= `SHADOW_LAST;
  wire rxPick = txIrSel ? rxIrValid : rxUartValid;
  reg wrPhase_r;
  reg rdPhase_r;
  // Data phase trackers, the write only lands one edge after its address
  always @(posedge mclk or posedge rst)
    if (rst)
    begin
      wrPhase_r <= 1'b0;
      rdPhase_r <= 1'b0;
    end
    else
    begin
      wrPhase_r <= hit && hwrite;
      rdPhase_r <= hit && !hwrite;
    end
  sequence wrLand;
    wrPhase_r && !txValid;
  endsequence
  sequence reachHead;
    ##2 txValid;
  endsequence
  okay_resp_a: assert property (hreadyout && !hresp) else $error("bus not ready or not OKAY");
  rx_ready_a: assert property (rxPick |=> rxByteReadyFlag) else $error("byte ready not raised");
  rx_overrun_a: assert property (rxPick && !fifoEnable && rxByteReadyFlag && !(hit && !hwrite) |=> overrunFlag)
    else $error("overrun not flagged");
  rd_upper_a: assert property (rdPhase_r |-> hrdata[31:8] == 24'h000000) else $error("upper read bits set");
  tx_empty_a: assert property (wrPhase_r |=> !txHoldingEmptyFlag) else $error("empty flag kept");
  tx_head_a: assert property (wrLand |-> reachHead) else $error("written byte not offered");
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txByte))
    else $error("offered byte changed");
  reset_state_a: assert property ($fell(rst) |-> !rxByteReadyFlag && !overrunFlag && txHoldingEmptyFlag)
    else $error("flags wrong after reset");
endmodule // uart_shadow_monitor

bind uart_shadow_data_port uart_shadow_monitor i_uart_shadow_monitor (.mclk(mclk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .rxUartValid(rxUartValid), .rxIrValid(rxIrValid), .txValid(txValid), .txByte(txByte),
  .txReady(txReady), .txIrSel(txIrSel), .rxByteReadyFlag(rxByteReadyFlag),
  .txHoldingEmptyFlag(txHoldingEmptyFlag), .overrunFlag(overrunFlag), .fifoEnable(fifoEnable));

// ---- verification/uart_far_model.sv ----
// Far-side transceiver: feeds received bytes and drains the transmit path
`timescale 1ns/1ps
module uart_far_model (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Transmit path
  input wire txValid,
  input wire [7:0] txByte,
  output wire txReady,
  // Receive path
  output logic rxUartValid,
  output logic [7:0] rxUartByte,
  output logic rxIrValid,
  output logic [7:0] rxIrByte
);
  logic stall = 1'b0;
  logic [7:0] got[$];
  initial
  begin
    rxUartValid = 1'b0;
    rxIrValid = 1'b0;
    rxUartByte = 8'h00;
    rxIrByte = 8'hFF;
  end
  // Shifter may hold off as long as it likes
  assign txReady = !stall;
  // Collect every byte taken by the shifter
  always @(posedge mclk)
    if (!rst && txValid && txReady)
      got.push_back(txByte);
  // One byte a call; lines then show the inverse so stale data never looks fresh
  task automatic send(input logic ir, input logic [7:0] b);
    @(posedge mclk);
    rxIrValid <= ir;
    rxUartValid <= !ir;
    rxIrByte <= b;
    rxUartByte <= b;
    @(posedge mclk);
    rxIrValid <= 1'b0;
    rxUartValid <= 1'b0;
    rxIrByte <= ~b;
    rxUartByte <= ~b;
  endtask
endmodule // uart_far_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the shadow data port
`timescale 1ns/1ps
`include "uart_shadow_defines.vh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  wire hready, hreadyout, hresp, rxUartValid, rxIrValid, txValid, txReady, txIrSel;
  wire rxByteReadyFlag, txHoldingEmptyFlag, overrunFlag, fifoEnable;
  wire [31:0] hrdata;
  wire [7:0] rxUartByte, rxIrByte, txByte;
  int error_cnt = 0;
  int compares = 0;
  int k;
  assign hready = hreadyout;
  // Bus clock, 8 ns period
  always #4 mclk = ~mclk;
  uart_shadow_data_port i_uart_shadow_data_port (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rxUartValid(rxUartValid), .rxUartByte(rxUartByte), .rxIrValid(rxIrValid),
    .rxIrByte(rxIrByte), .txValid(txValid), .txByte(txByte), .txReady(txReady), .txIrSel(txIrSel),
    .rxByteReadyFlag(rxByteReadyFlag), .txHoldingEmptyFlag(txHoldingEmptyFlag), .overrunFlag(overrunFlag),
    .fifoEnable(fifoEnable));
  uart_far_model i_uart_far_model (.mclk(mclk), .rst(rst), .txValid(txValid), .txByte(txByte),
    .txReady(txReady), .rxUartValid(rxUartValid), .rxUartByte(rxUartByte), .rxIrValid(rxIrValid),
    .rxIrByte(rxIrByte));
  // One single transfer; entered just after a rising edge
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
    logic [31:0] x;
    xfer(a, 1'b0, 32'h00000000, x);
    `CHK(n, e, x & m)
  endtask
  // Shifter drain, bounded so a stuck path shows as a short count
  task automatic drain(input int n);
    for (int i = 0; i < 300 && (i_uart_far_model.got.size() < n || txValid !== 1'b0); i++) @(posedge mclk);
  endtask
  task automatic final_report;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests take
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    final_report;
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Reset state and an unmapped place
    rdc(`STAT_ADDR, 32'h00000020, 32'hFFFFFFFF, "stat reset");
    rdc(`SHADOW_THIS, 32'h00000000, 32'hFFFFFFFF, "data reset");
    wr(32'h50001200, 32'h00000003);
    rdc(`CTRL_ADDR, 32'h00000000, 32'h00000003, "ctrl");
    rdc(32'h50001200, 32'h00000000, 32'hFFFFFFFF, "unmapped");
    // Plain buffer: read, then overwrite with overrun
    i_uart_far_model.send(1'b0, 8'hA5);
    rdc(`STAT_ADDR, 32'h00000021, 32'h000000FF, "stat ready");
    rdc(`SHADOW_THIS, 32'h000000A5, 32'hFFFFFFFF, "rx uart");
    i_uart_far_model.send(1'b0, 8'h5A);
    i_uart_far_model.send(1'b0, 8'hC3);
    rdc(`STAT_ADDR, 32'h00000023, 32'h000000FF, "stat overrun");
    rdc(`SHADOW_BASE, 32'h000000C3, 32'hFFFFFFFF, "rx overwrite");
    rdc(`STAT_ADDR, 32'h00000020, 32'h000000FF, "stat cleared");
    // Infrared receive; the UART line is then ignored
    wr(`CTRL_ADDR, 32'h00000002);
    // Control outputs only settle after the write edge
    @(negedge mclk);
    `CHK("ir select", 1'b1, txIrSel)
    i_uart_far_model.send(1'b1, 8'h3C);
    i_uart_far_model.send(1'b0, 8'h77);
    rdc(`SHADOW_LAST, 32'h0000003C, 32'hFFFFFFFF, "rx ir");
    // FIFO receive: one past full, then drain across every alias
    wr(`CTRL_ADDR, 32'h00000001);
    @(negedge mclk);
    `CHK("fifo enable", 1'b1, fifoEnable)
    for (k = 0; k < 17; k++) i_uart_far_model.send(1'b0, 8'h10 + k[7:0]);
    rdc(`STAT_ADDR, 32'h00001063, 32'hFFFFFFFF, "stat rx full");
    for (k = 0; k < 16; k++)
      rdc(`SHADOW_BASE + {26'h0, k[3:0], 2'h0}, {24'h0, 8'h10 + k[7:0]}, 32'hFFFFFFFF, "rx fifo");
    rdc(`STAT_ADDR, 32'h00000020, 32'hFFFFFFFF, "stat rx drained");
    // Plain holding byte, shifter stalled: once the shifter buffer is full, a later write replaces the pending one
    wr(`CTRL_ADDR, 32'h00000000);
    rdc(`STAT_ADDR, 32'h00000020, 32'h00000020, "tx empty before write");
    i_uart_far_model.stall <= 1'b1;
    for (k = 1; k < 5; k++) wr(`SHADOW_THIS, {24'hFFFFFF, k[3:0], k[3:0]});
    rdc(`STAT_ADDR, 32'h00000000, 32'h000000FF, "stat tx pending");
    i_uart_far_model.stall <= 1'b0;
    drain(3);
    `CHK("tx plain", 24'h112244, {i_uart_far_model.got[0], i_uart_far_model.got[1], i_uart_far_model.got[2]})
    `CHK("tx plain count", 3, i_uart_far_model.got.size())
    // FIFO transmit: sixteen stored plus two in the buffer, the rest lost
    wr(`CTRL_ADDR, 32'h00000001);
    i_uart_far_model.stall <= 1'b1;
    i_uart_far_model.got.delete();
    for (k = 0; k < 20; k++) wr(`SHADOW_THIS, {24'h0, 8'h40 + k[7:0]});
    rdc(`STAT_ADDR, 32'h00100080, 32'hFFFFFFFF, "stat tx full");
    i_uart_far_model.stall <= 1'b0;
    drain(18);
    `CHK("tx fifo count", 18, i_uart_far_model.got.size())
    `CHK("tx fifo ends", 16'h4051, {i_uart_far_model.got[0], i_uart_far_model.got[17]})
    final_report;
  end
endmodule // tb_top
